// file: logic/bmbc_pkg.sv
// Package for the backup mode and bus control block
package bmbc_pkg;
	// Mode selection bit positions within the mode word
	localparam int MODE_SWITCH_BIT  = 0;
	localparam int MODE_INHIBIT_BIT = 1;
	// Reset values of the configuration bits (standard switchover, bus kept)
	localparam logic RST_SWITCHOVER_SELECT = 1'h0;
	localparam logic RST_BACKUP_BUS_INHIBIT = 1'h0;
	// Supply comparator results, all active high
	typedef struct packed {
		logic vddBelowTrip;   // Supply below trip_threshold
		logic vddBelowBat;    // Supply below battery voltage
	} bmbc_cmp_type;
	// Status outputs
	typedef struct packed {
		logic onBattery;      // Device running from battery
		logic busEnable;      // Serial interface usable
		logic nvmEnable;      // Non-volatile memory access allowed
	} bmbc_stat_type;
	// Power states
	typedef enum logic [0:0] {
		ST_MAIN,
		ST_BACKUP
	} bmbc_state_type;
endpackage

// file: logic/bmbc_switch_cond.sv
// Switchover condition decoder for the backup mode and bus control block
`timescale 1ns/100ps
`default_nettype none
module bmbc_switch_cond
	import bmbc_pkg::*;
(
	input  wire bmbc_pkg::bmbc_cmp_type cmpIn,
	input  wire logic                   switchoverSelect,
	output logic                        dropToBattery
);
	// Standard: below lower of threshold or battery; legacy: below battery
	wire stdCond    = cmpIn.vddBelowTrip & cmpIn.vddBelowBat;
	wire legacyCond = cmpIn.vddBelowBat;
	assign dropToBattery = switchoverSelect ? legacyCond : stdCond;
endmodule
`default_nettype wire

// file: logic/backup_mode_bus_control.sv
// Backup entry, bus inhibit and ungated alarm output drive for the real-time clock
`timescale 1ns/100ps
`default_nettype none
module backup_mode_bus_control
	import bmbc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire bmbc_pkg::bmbc_cmp_type cmpIn,
	input  wire logic                   cfgWrite,
	input  wire logic                   cfgSwitchoverSelect,
	input  wire logic                   cfgBackupBusInhibit,
	input  wire logic                   busSclIn,
	input  wire logic                   busSdaIn,
	input  wire logic                   busSdaDriveLow,
	input  wire logic                   alarmFreqDriveLow,
	output logic                        busSclCore,
	output logic                        busSdaCore,
	output logic                        busSdaOe_n,
	output logic                        alarm_freq_out_o,
	output logic                        alarm_freq_out_oe_n,
	output bmbc_pkg::bmbc_stat_type     status,
	output logic                        switchover_select,
	output logic                        backup_bus_inhibit
);
	import bmbc_pkg::*;

	// Configuration bits
	logic           switchoverSelect_ff;
	logic           busInhibit_ff;
	// Power state
	bmbc_state_type state_ff;
	bmbc_state_type nxt_state;
	// Registered status
	bmbc_stat_type  status_ff;
	// Combinational decode
	logic           dropToBattery;
	logic           busAllowed;
	logic           onBattery;

	// Configuration bits, loaded by the serial interface core
	// A write that arrives while the bus is cut comes from a dead bus,
	// so it is dropped rather than trusted
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			switchoverSelect_ff <= RST_SWITCHOVER_SELECT;
			busInhibit_ff       <= RST_BACKUP_BUS_INHIBIT;
		end
		else if (cfgWrite && busAllowed)
		begin
			switchoverSelect_ff <= cfgSwitchoverSelect;
			busInhibit_ff       <= cfgBackupBusInhibit;
		end
	end

	bmbc_switch_cond u_cond (
		.cmpIn            (cmpIn),
		.switchoverSelect (switchoverSelect_ff),
		.dropToBattery    (dropToBattery)
	);

	// Next power state from the chosen condition
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_MAIN:
			begin
				if (dropToBattery)
					nxt_state = ST_BACKUP;
			end
			ST_BACKUP:
			begin
				if (!dropToBattery)
					nxt_state = ST_MAIN;
			end
			default:
				nxt_state = ST_MAIN;
		endcase
	end

	// Power state register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_ff <= ST_MAIN;
		else
			state_ff <= nxt_state;
	end

	assign onBattery = (state_ff == ST_BACKUP);
	// inhibit bit kills bus in backup
	assign busAllowed = !(onBattery && busInhibit_ff);

	// Status register; memory never usable on battery
	// One edge behind the state, so readers see a settled value
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			status_ff <= '0;
		else
		begin
			status_ff.onBattery <= onBattery;
			status_ff.busEnable <= busAllowed;
			status_ff.nvmEnable <= !onBattery;
		end
	end

	// Bus gating: inhibited bus sees idle high lines, never drives
	// Idle high keeps the serial core from seeing a false start
	assign busSclCore = busAllowed ? busSclIn : 1'h1;
	assign busSdaCore = busAllowed ? busSdaIn : 1'h1;
	assign busSdaOe_n = !(busAllowed && busSdaDriveLow);

	assign alarm_freq_out_o    = 1'h0;
	assign alarm_freq_out_oe_n = !alarmFreqDriveLow;

	assign status             = status_ff;
	assign switchover_select  = switchoverSelect_ff;
	assign backup_bus_inhibit = busInhibit_ff;

	// Checks on mode decode, bus gating and the power state

	// standard mode entry within one edge
	std_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!switchoverSelect_ff && cmpIn.vddBelowTrip && cmpIn.vddBelowBat && !onBattery)
		|=> onBattery)
		else $error("standard switchover missed");
	// legacy mode waits for supply below battery
	legacy_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
		(switchoverSelect_ff && !cmpIn.vddBelowBat && !onBattery) |=> !onBattery)
		else $error("legacy entered backup early");
	// bus off while inhibited in backup
	bus_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		(onBattery && busInhibit_ff) |-> (busSdaOe_n && busSclCore && busSdaCore))
		else $error("bus active while inhibited");
	bus_status_a: assert property (@(posedge clk) disable iff (sys_rst)
		(onBattery && busInhibit_ff) |=> !status.busEnable)
		else $error("bus status not cleared");
	// bus alive in backup when not inhibited
	bus_alive_a: assert property (@(posedge clk) disable iff (sys_rst)
		(onBattery && !busInhibit_ff && busSdaDriveLow) |-> !busSdaOe_n)
		else $error("bus blocked without inhibit");
	// alarm output follows request in every state
	alarm_live_a: assert property (@(posedge clk) disable iff (sys_rst)
		alarmFreqDriveLow |-> !alarm_freq_out_oe_n)
		else $error("alarm output blocked");

	// Entry steps: state first, registered status one edge later
	sequence entrySteps;
		onBattery ##1 status.onBattery;
	endsequence
	// Exit steps: back on supply, bus reported usable one edge later
	sequence exitSteps;
		!onBattery ##1 status.busEnable;
	endsequence
	// leave backup one edge after recovery
	exit_backup_a: assert property (@(posedge clk) disable iff (sys_rst)
		(onBattery && !dropToBattery) |=> exitSteps)
		else $error("backup exit late");
	// standard selection holds until a write
	std_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!switchoverSelect_ff && !cfgWrite) |=> !switchoverSelect_ff)
		else $error("select changed without write");

	// entry visible in state, then in status
	entry_steps_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!onBattery && dropToBattery) |=> entrySteps)
		else $error("backup entry not reported");
	// legacy mode enters once supply is below battery
	legacy_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
		(switchoverSelect_ff && cmpIn.vddBelowBat && !onBattery) |=> onBattery)
		else $error("legacy switchover missed");
	// standard mode ignores supply below only one level
	std_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!switchoverSelect_ff && !(cmpIn.vddBelowTrip && cmpIn.vddBelowBat) && !onBattery)
		|=> !onBattery)
		else $error("standard entered backup early");
	// pads pass straight through while the bus is allowed
	bus_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!onBattery || !busInhibit_ff)
		|-> (busSclCore == busSclIn && busSdaCore == busSdaIn))
		else $error("bus not passed through");

	// writes are dropped while the bus is cut
	refused_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		(cfgWrite && onBattery && busInhibit_ff)
		|=> ($stable(switchoverSelect_ff) && $stable(busInhibit_ff)))
		else $error("write taken while inhibited");
	// bus usable again on the first edge back on supply
	bus_back_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(onBattery)
		|-> (busSclCore == busSclIn && busSdaOe_n == !busSdaDriveLow))
		else $error("bus not restored after backup");
	// select loads the written value on an accepted write
	cfg_load_a: assert property (@(posedge clk) disable iff (sys_rst)
		(cfgWrite && busAllowed)
		|=> (switchoverSelect_ff == $past(cfgSwitchoverSelect)))
		else $error("accepted write not loaded");

	// alarm pin released whenever alarm logic lets go
	alarm_release_a: assert property (@(posedge clk) disable iff (sys_rst)
		!alarmFreqDriveLow |-> (alarm_freq_out_oe_n && !alarm_freq_out_o))
		else $error("alarm output stuck low");
	// memory access never granted on battery
	nvm_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		onBattery |=> !status.nvmEnable)
		else $error("memory enabled on battery");
endmodule
`default_nettype wire

// file: verif/bmbc_mcu_model.sv
// Microcontroller stand-in driving the two-wire serial bus pads
`timescale 1ns/100ps
`default_nettype none
module bmbc_mcu_model
(
	input  wire logic clk,
	output logic      scl,
	output logic      sda
);
	// Free-running bus activity counter
	logic [1:0] cnt_ff = 2'h0;
	// Clock changes every cycle and data every second cycle, so a stale clock pad value never passes as a match
	always_ff @(posedge clk)
	begin
		cnt_ff <= cnt_ff + 2'h1;
	end
	// Clock and data lines
	assign scl = cnt_ff[0];
	assign sda = cnt_ff[1];
endmodule
`default_nettype wire

// file: verif/backup_mode_bus_control_bench.sv
// Self-checking bench for backup mode entry and bus gating
`timescale 1ns/100ps
`default_nettype none
module backup_mode_bus_control_bench;
	import bmbc_pkg::*;
	logic clk = 0, sys_rst = 1, cfgWrite = 0, cfgSel = 0, cfgInh = 0, drv = 0;
	bmbc_cmp_type cmpIn = 2'h0;
	wire logic mcuScl, mcuSda, sclCore, sdaCore, sdaOe_n, afO, afOe_n, selQ, inhQ;
	bmbc_stat_type status;
	int n_mismatch = 0;
	int cmp_count = 0;
	// Open-drain data wire level seen by the DUT; the MCU model and the DUT both pull it low
	wire logic sdaWire = mcuSda & sdaOe_n;
	always #20 clk = ~clk;
	bmbc_mcu_model mcu_u (.clk(clk), .scl(mcuScl), .sda(mcuSda));
	backup_mode_bus_control dut_u (.clk(clk), .sys_rst(sys_rst), .cmpIn(cmpIn),
		.cfgWrite(cfgWrite), .cfgSwitchoverSelect(cfgSel), .cfgBackupBusInhibit(cfgInh),
		.busSclIn(mcuScl), .busSdaIn(sdaWire), .busSdaDriveLow(drv),
		.alarmFreqDriveLow(drv), .busSclCore(sclCore), .busSdaCore(sdaCore),
		.busSdaOe_n(sdaOe_n), .alarm_freq_out_o(afO), .alarm_freq_out_oe_n(afOe_n),
		.status(status), .switchover_select(selQ), .backup_bus_inhibit(inhQ));
	// Comparison with report
	task chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Advance n edges, then settle
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Power-up defaults
	task test_reset;
		chk("rstStat", status, 3'h3);
		chk("rstCfg", {1'b0, selQ, inhQ}, 3'h0);
		$display("reset test done");
	endtask
	// One mode: entry, gating, write in backup (refused when inhibited), recovery
	task test_mode(input logic s, input logic i);
		cfgSel = s; cfgInh = i; cfgWrite = 1; step(1); cfgWrite = 0;
		chk("cfg", {1'b0, selQ, inhQ}, {1'b0, s, i});
		cmpIn = 2'h2; step(2);
		chk("tripOnly", {2'h0, status.onBattery}, 3'h0);
		cmpIn = 2'h1; step(2);
		chk("legacyEntry", {2'h0, status.onBattery}, {2'h0, s});
		cmpIn = 2'h3; drv = 1; step(2);
		chk("backupStat", status, {1'b1, ~i, 1'b0});
		chk("sclGate", {2'h0, sclCore}, {2'h0, i | mcuScl});
		chk("sdaGate", {2'h0, sdaOe_n}, {2'h0, i});
		chk("sdaCore", {2'h0, sdaCore}, {2'h0, i});
		chk("alarmOut", {1'b0, afO, afOe_n}, 3'h0);
		cfgWrite = 1; cfgInh = 0; cfgSel = ~s; step(1); cfgWrite = 0;
		chk("cfgHold", {1'b0, selQ, inhQ}, i ? {1'b0, s, i} : {1'b0, ~s, 1'b0});
		cmpIn = 2'h0; drv = 0; step(2);
		chk("recover", status, 3'h3);
		chk("sclFree", {2'h0, sclCore}, {2'h0, mcuScl});
		chk("sdaFree", {2'h0, sdaCore}, {2'h0, mcuSda});
		chk("alarmIdle", {2'h0, afOe_n}, 3'h1);
		$display("mode select %0d inhibit %0d done", s, i);
	endtask
	// Verdict and end of run
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		#1 sys_rst = 0;
		step(1);
		test_reset;
		for (int m = 0; m < 4; m++)
			test_mode(m[0], m[1]);
		results;
	end
	// Watchdog against a hang
	initial
	begin
		#(40 * 400);
		n_mismatch++;
		results;
	end
endmodule
`default_nettype wire
